/* File: rtl/dmr_defs.svh */
`ifndef DMR_DEFS_SVH
`define DMR_DEFS_SVH
// register indices on the plain register port
`define DMR_OFS_LOOP_CTRL 3'h0
`define DMR_OFS_REF_CHG 3'h1
`define DMR_OFS_SOFT_DF 3'h2
`define DMR_OFS_BW_CTRL 3'h3
`define DMR_OFS_LOCK_RANGE 3'h4
`define DMR_OFS_CENTRE 3'h5
`define DMR_OFS_STATUS 3'h6
`define DMR_OFS_FREQ 3'h7
// loop control fields
`define DMR_BIT_IRM 0
`define DMR_BIT_SWE 3
`define DMR_BIT_SWF 4
`define DMR_BIT_SLV_EN 5
// reference change control fields
`define DMR_OPM_LSB 0
`define DMR_OPM_MSB 1
`define DMR_PMS_LSB 2
`define DMR_PMS_MSB 4
`define DMR_SEL_LSB 5
`define DMR_SEL_MSB 6
// bandwidth control fields
`define DMR_GAIN_LSB 0
`define DMR_GAIN_MSB 3
`define DMR_BIT_BYPASS 13
// preference modes
`define DMR_PMS_NONE 3'h0
`define DMR_PMS_PREF 3'h1
// reset values
`define DMR_RST_LOOP_CTRL 16'h0000
`define DMR_RST_REF_CHG 16'h0002
`define DMR_RST_SOFT_DF 16'h0000
`define DMR_RST_BW_CTRL 16'h0004
`define DMR_RST_LOCK_RANGE 14'h0100
`define DMR_RST_CENTRE 16'h1000
// timing
`define DMR_CLK_PERIOD_NS 10
`define DMR_HOLD_SAVE_NS 1000000
`define DMR_FRAME_TICKS 10'h3FF
`endif

/* File: rtl/dmr_pkg.sv */
package dmr_pkg;
  typedef enum logic [1:0] {
    DMR_OPM_NORMAL = 2'h0,
    DMR_OPM_HOLD = 2'h1,
    DMR_OPM_AUTO = 2'h2,
    DMR_OPM_FREE = 2'h3
  } dmr_opmode_t;

  typedef enum logic [3:0] {
    DMR_ST_IDLE = 4'b0001,
    DMR_ST_TRACK = 4'b0010,
    DMR_ST_HOLD = 4'b0100,
    DMR_ST_FREE = 4'b1000
  } dmr_state_t;

  typedef struct packed {
    logic [2:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } dmr_reg_req_t;

  typedef struct packed {
    logic [3:0] valid;
    logic signed [15:0] phase_err;
  } dmr_ref_status_t;
endpackage : dmr_pkg

/* File: rtl/dmr_loop_ctrl.sv */
`timescale 1ns/1ps
`include "dmr_defs.svh"
// Summary of operation
// RULE1 - four references in, six clocks, five pulses
// RULE2 - software forces track, preference, holdover, freerun
// RULE3 - normal, holdover, auto, freerun plus internal reset
// RULE4 - normal mode tracks active reference, filtered
// RULE5 - holdover ignores references, keeps prior frequency
// RULE6 - periodic frequency save; restore older saved value
// RULE7 - holdover frequency stays at last valid value
// RULE8 - auto mode: machine chooses normal or holdover
// RULE9 - preference 000: round robin 0,1,2,3,0
// RULE10 - preference 001: primary and next as secondary
// RULE11 - host reprograms for other reference schemes
// RULE12 - freerun locks nothing, uses centre frequency
// RULE13 - freerun adds no error over oscillator
// RULE14 - host never mixes freerun with fast lock
// RULE15 - soft frequency mode only in freerun, bit 3
// RULE16 - bit 4 clear: glide to offset, slope limited; the code jumps instead when bandwidth control bit 13 is set
// RULE17 - bit 4 set: jump to offset after write
// RULE18 - offset ignored unless enabled and freerunning
// RULE19 - bit 0 holds loop in reset, clocks stop
// RULE20 - registers stay accessible and keep values
// RULE21 - locking range is programmable
// RULE22 - slave operation: loop off until enabled
// RULE23 - leaving reset restarts from held settings
module dmr_loop_ctrl #(
  parameter int P_HOLD_SAVE_CYC = `DMR_HOLD_SAVE_NS / `DMR_CLK_PERIOD_NS
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire dmr_pkg::dmr_reg_req_t i_req,
  input wire dmr_pkg::dmr_ref_status_t i_ref,
  input wire logic i_slave_mode,
  output logic [15:0] o_rdata,
  output logic [5:0] o_clk_out,
  output logic [4:0] o_frame_pulse,
  output logic [1:0] o_active_ref,
  output logic o_holdover
);
  import dmr_pkg::*;

  logic [15:0] ctrl_reg;
  logic [15:0] refchg_reg;
  logic signed [15:0] sdf_reg;
  logic [15:0] bw_reg;
  logic [13:0] range_reg;
  logic [15:0] centre_reg;
  dmr_state_t st_reg, st_next;
  logic [1:0] act_reg, act_next;
  logic signed [15:0] freq_reg, hist0_reg, hist1_reg;
  logic [31:0] save_cnt_reg;
  logic [15:0] acc_reg;
  logic [9:0] fr_cnt_reg;
  logic [15:0] rdata_next;
  logic run, irm, soft_freq_enable, soft_freq_immediate, cand_ok;
  logic [1:0] cand, sel;
  logic [2:0] pms;
  dmr_opmode_t opm;
  logic signed [16:0] trk_sum, lim_hi, lim_lo;
  logic [16:0] acc_sum;

  assign irm = ctrl_reg[`DMR_BIT_IRM];
  assign soft_freq_enable = ctrl_reg[`DMR_BIT_SWE];
  assign soft_freq_immediate = ctrl_reg[`DMR_BIT_SWF];
  assign opm = dmr_opmode_t'(refchg_reg[`DMR_OPM_MSB:`DMR_OPM_LSB]);
  assign pms = refchg_reg[`DMR_PMS_MSB:`DMR_PMS_LSB];
  assign sel = refchg_reg[`DMR_SEL_MSB:`DMR_SEL_LSB];
  // loop runs unless held in reset; in slave operation only when enabled
  assign run = !irm && // see RULE19
    (!i_slave_mode || ctrl_reg[`DMR_BIT_SLV_EN]); // see RULE22

  // registers are never touched by the internal reset
  always_ff @(posedge i_clk) begin // see RULE20
    if (!i_rst_n) begin
      ctrl_reg <= `DMR_RST_LOOP_CTRL;
      refchg_reg <= `DMR_RST_REF_CHG;
      sdf_reg <= `DMR_RST_SOFT_DF;
      bw_reg <= `DMR_RST_BW_CTRL;
      range_reg <= `DMR_RST_LOCK_RANGE;
      centre_reg <= `DMR_RST_CENTRE;
    end else if (i_ce && i_req.wr) begin // see RULE2
      case (i_req.addr)
        `DMR_OFS_LOOP_CTRL: ctrl_reg <= i_req.wdata;
        `DMR_OFS_REF_CHG: refchg_reg <= i_req.wdata;
        `DMR_OFS_SOFT_DF: sdf_reg <= i_req.wdata;
        `DMR_OFS_BW_CTRL: bw_reg <= i_req.wdata;
        `DMR_OFS_LOCK_RANGE: range_reg <= i_req.wdata[13:0]; // see RULE21
        `DMR_OFS_CENTRE: centre_reg <= i_req.wdata;
        default: begin
        end
      endcase
    end
  end

  always_comb begin
    case (i_req.addr)
      `DMR_OFS_LOOP_CTRL: rdata_next = ctrl_reg;
      `DMR_OFS_REF_CHG: rdata_next = refchg_reg;
      `DMR_OFS_SOFT_DF: rdata_next = sdf_reg;
      `DMR_OFS_BW_CTRL: rdata_next = bw_reg;
      `DMR_OFS_LOCK_RANGE: rdata_next = {2'h0, range_reg};
      `DMR_OFS_CENTRE: rdata_next = centre_reg;
      `DMR_OFS_STATUS: rdata_next = {9'h000, run, st_reg, act_reg};
      default: rdata_next = freq_reg;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_rdata <= 16'h0000;
    end else if (i_ce) begin
      o_rdata <= i_req.rd ? rdata_next : 16'h0000;
    end
  end

  // reference candidate for automatic mode
  always_comb begin // see RULE8
    cand = act_reg;
    cand_ok = 1'b0;
    if (pms == `DMR_PMS_PREF) begin // see RULE10
      if (i_ref.valid[sel]) begin
        cand = sel;
        cand_ok = 1'b1;
      end else if (i_ref.valid[2'(sel + 2'h1)]) begin
        cand = 2'(sel + 2'h1);
        cand_ok = 1'b1;
      end
    end else if (i_ref.valid[act_reg]) begin
      cand_ok = 1'b1;
    end else begin
      for (int k = 3; k >= 1; k--) begin // see RULE9
        if (i_ref.valid[2'(act_reg + 2'(k))]) begin
          cand = 2'(act_reg + 2'(k));
          cand_ok = 1'b1;
        end
      end
    end
  end

  // mode machine; restarts from idle after internal reset
  always_comb begin // see RULE3 see RULE23
    act_next = act_reg;
    case (opm)
      DMR_OPM_NORMAL: begin
        st_next = DMR_ST_TRACK;
        act_next = sel;
      end
      DMR_OPM_HOLD: st_next = DMR_ST_HOLD;
      DMR_OPM_FREE: st_next = DMR_ST_FREE;
      default: begin
        st_next = cand_ok ? DMR_ST_TRACK : DMR_ST_HOLD;
        act_next = cand;
      end
    endcase
    case (st_reg)
      DMR_ST_IDLE, DMR_ST_TRACK, DMR_ST_HOLD, DMR_ST_FREE: begin
        if (!run) begin
          st_next = DMR_ST_IDLE;
        end
      end
      default: st_next = DMR_ST_IDLE;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      st_reg <= DMR_ST_IDLE;
      act_reg <= 2'h0;
    end else if (i_ce) begin
      st_reg <= st_next;
      act_reg <= act_next;
    end
  end

  // tracking step, clamped to the programmed locking range
  assign trk_sum = 17'(freq_reg) +
    17'(i_ref.phase_err >>> bw_reg[`DMR_GAIN_MSB:`DMR_GAIN_LSB]); // see RULE4
  assign lim_hi = 17'({3'h0, range_reg});
  assign lim_lo = -lim_hi;

  // loop frequency offset; internal reset only acts while enabled
  always_ff @(posedge i_clk) begin
    if (!i_rst_n || (i_ce && !run)) begin
      freq_reg <= 16'h0000;
    end else if (i_ce) begin
      case (st_next)
        DMR_ST_TRACK: begin
          if (trk_sum > lim_hi) begin // see RULE21
            freq_reg <= lim_hi[15:0];
          end else if (trk_sum < lim_lo) begin
            freq_reg <= lim_lo[15:0];
          end else begin
            freq_reg <= trk_sum[15:0];
          end
        end
        DMR_ST_HOLD: begin // see RULE5 see RULE7
          if (st_reg == DMR_ST_TRACK) begin
            freq_reg <= hist1_reg; // see RULE6
          end
        end
        DMR_ST_FREE: begin
          if (!soft_freq_enable) begin
            freq_reg <= 16'h0000; // see RULE12 see RULE13 see RULE18
          end else if (soft_freq_immediate || bw_reg[`DMR_BIT_BYPASS]) begin
            freq_reg <= sdf_reg; // see RULE15 see RULE17
          end else if (freq_reg < sdf_reg) begin
            freq_reg <= freq_reg + 16'sh0001; // see RULE16
          end else if (freq_reg > sdf_reg) begin
            freq_reg <= freq_reg - 16'sh0001;
          end
        end
        default: freq_reg <= 16'h0000;
      endcase
    end
  end

  // holdover memory: two saved values, the older one is restored
  always_ff @(posedge i_clk) begin // see RULE6
    if (!i_rst_n || (i_ce && !run)) begin
      save_cnt_reg <= 32'h0000_0000;
      hist0_reg <= 16'h0000;
      hist1_reg <= 16'h0000;
    end else if (i_ce && st_reg == DMR_ST_TRACK) begin
      if (save_cnt_reg >= 32'(P_HOLD_SAVE_CYC - 1)) begin
        save_cnt_reg <= 32'h0000_0000;
        hist0_reg <= freq_reg;
        hist1_reg <= hist0_reg;
      end else begin
        save_cnt_reg <= save_cnt_reg + 32'h0000_0001;
      end
    end
  end

  // oscillator: centre plus offset; clocks and pulses derived from it
  assign acc_sum = {1'b0, acc_reg} + {1'b0, centre_reg + freq_reg};

  always_ff @(posedge i_clk) begin // see RULE1
    if (!i_rst_n || (i_ce && !run)) begin
      acc_reg <= 16'h0000;
      fr_cnt_reg <= 10'h000;
    end else if (i_ce) begin
      acc_reg <= acc_sum[15:0];
      if (acc_sum[16]) begin
        fr_cnt_reg <= (fr_cnt_reg == `DMR_FRAME_TICKS) ? 10'h000 :
          fr_cnt_reg + 10'h001;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_clk_out <= 6'h00;
      o_frame_pulse <= 5'h00;
      o_active_ref <= 2'h0;
      o_holdover <= 1'b0;
    end else if (i_ce) begin
      o_clk_out <= run ? acc_reg[15:10] : 6'h00; // see RULE19
      for (int i = 0; i < 5; i++) begin
        o_frame_pulse[i] <= run && (fr_cnt_reg <= 10'(i));
      end
      o_active_ref <= act_reg;
      o_holdover <= (st_reg == DMR_ST_HOLD);
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  sequence s_enter_hold;
    i_ce && run && st_reg == DMR_ST_TRACK && st_next == DMR_ST_HOLD;
  endsequence

  sequence s_soft_write;
    i_ce && run && i_req.wr && i_req.addr == `DMR_OFS_SOFT_DF &&
      st_reg == DMR_ST_FREE && opm == DMR_OPM_FREE && soft_freq_enable && soft_freq_immediate;
  endsequence

  a_irm_clk_off: assert property ( // see RULE19
    i_ce && irm |=> o_clk_out == 6'h00 && o_frame_pulse == 5'h00)
    else $error("clocks running in internal reset");

  a_regs_kept: assert property ( // see RULE20
    irm && !i_req.wr |=> $stable(refchg_reg) && $stable(sdf_reg))
    else $error("register changed without a write");

  a_hold_restore: assert property ( // see RULE6
    s_enter_hold |=> freq_reg == $past(hist1_reg))
    else $error("holdover did not restore saved value");

  a_hold_stable: assert property ( // see RULE5
    i_ce && st_reg == DMR_ST_HOLD && st_next == DMR_ST_HOLD
      |=> $stable(freq_reg))
    else $error("frequency moved in holdover");

  a_free_centre: assert property ( // see RULE18
    i_ce && run && st_next == DMR_ST_FREE && !soft_freq_enable |=> freq_reg == 16'h0000)
    else $error("freerun offset not zero");

  a_soft_jump: assert property ( // see RULE17
    s_soft_write ##1 (i_ce && run && opm == DMR_OPM_FREE)
      |=> freq_reg == $past(sdf_reg))
    else $error("immediate offset not reached");

  a_rr_order: assert property ( // see RULE9
    i_ce && run && opm == DMR_OPM_AUTO && pms == `DMR_PMS_NONE &&
      !i_ref.valid[act_reg] && i_ref.valid[2'(act_reg + 2'h1)]
      |=> act_reg == 2'($past(act_reg) + 2'h1))
    else $error("round robin order broken");

  a_pref_primary: assert property ( // see RULE10
    i_ce && run && opm == DMR_OPM_AUTO && pms == `DMR_PMS_PREF &&
      i_ref.valid[sel] |=> act_reg == $past(sel) && st_reg == DMR_ST_TRACK)
    else $error("preferred reference not used");

  a_slave_off: assert property ( // see RULE22
    i_ce && i_slave_mode && !ctrl_reg[`DMR_BIT_SLV_EN]
      |=> st_reg == DMR_ST_IDLE && o_clk_out == 6'h00)
    else $error("slave loop active while disabled");

endmodule : dmr_loop_ctrl

/* File: bench/dmr_ref_src.sv */
`timescale 1ns/1ps
module dmr_ref_src (
  input wire logic i_clk,
  input wire logic i_slow,
  input wire logic [3:0] i_valid,
  output dmr_pkg::dmr_ref_status_t o_ref
);
  import dmr_pkg::*;
  logic [3:0] dly_reg [4];
  logic [3:0] cnt_reg = 4'h0;
  // a slow source reports quality changes four cycles late
  always_ff @(posedge i_clk) begin
    dly_reg[0] <= i_valid;
    for (int i = 1; i < 4; i++) begin
      dly_reg[i] <= dly_reg[i-1];
    end
    cnt_reg <= cnt_reg + 4'h1;
    o_ref.valid <= i_slow ? dly_reg[3] : i_valid;
    // phase error wanders every cycle, never parked
    o_ref.phase_err <= {{13{cnt_reg[3]}}, cnt_reg[2:0]};
  end
endmodule : dmr_ref_src

/* File: bench/dpll_mode_reference_control_test.sv */
`timescale 1ns/1ps
`include "dmr_defs.svh"
module dpll_mode_reference_control_test;
  import dmr_pkg::*;
  logic i_clk, i_rst_n, i_ce, i_slave_mode, slow;
  dmr_reg_req_t req;
  dmr_ref_status_t ref_st;
  logic [3:0] want_valid;
  logic [15:0] o_rdata, v, tgt;
  logic [5:0] o_clk_out;
  logic [4:0] o_frame_pulse;
  logic [1:0] o_active_ref, r;
  logic o_holdover;
  int n_errors = 0;
  int cmp_count = 0;
  int cyc = 0;
  logic [15:0] rst_tab [6] = '{`DMR_RST_LOOP_CTRL, `DMR_RST_REF_CHG,
    `DMR_RST_SOFT_DF, `DMR_RST_BW_CTRL, {2'h0, `DMR_RST_LOCK_RANGE},
    `DMR_RST_CENTRE};

  dmr_loop_ctrl #(.P_HOLD_SAVE_CYC(8)) i_dut (.i_clk(i_clk),
    .i_rst_n(i_rst_n), .i_ce(i_ce), .i_req(req), .i_ref(ref_st),
    .i_slave_mode(i_slave_mode), .o_rdata(o_rdata), .o_clk_out(o_clk_out),
    .o_frame_pulse(o_frame_pulse), .o_active_ref(o_active_ref),
    .o_holdover(o_holdover));
  dmr_ref_src i_src (.i_clk(i_clk), .i_slow(slow), .i_valid(want_valid),
    .o_ref(ref_st));

  task automatic test_done();
    if (n_errors == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : test_done
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge i_clk) req <= '{a, d, 1'b1, 1'b0};
    @(posedge i_clk) req <= '{a, d, 1'b0, 1'b0};
  endtask : wr
  // data stands one cycle after the strobe and is seen at the next edge
  task automatic rd(input logic [2:0] a, output logic [15:0] d);
    @(posedge i_clk) req <= '{a, 16'h0000, 1'b0, 1'b1};
    @(posedge i_clk) req <= '{a, 16'h0000, 1'b0, 1'b0};
    @(posedge i_clk) d = o_rdata;
  endtask : rd
  task automatic rdchk(input logic [2:0] a, input logic [15:0] e);
    logic [15:0] d;
    rd(a, d);
    chk(d, e);
  endtask : rdchk
  function automatic logic [1:0] nxt(input logic [1:0] x);
    return x + 2'h1;
  endfunction : nxt
  function automatic logic [15:0] rcc(input logic [1:0] sel,
      input logic [2:0] pms, input logic [1:0] mode);
    return {9'h000, sel, pms, mode};
  endfunction : rcc
  // in holdover the active index is not looked at
  task automatic wait_ref(input logic [1:0] x, input logic h);
    for (int i = 0; i < 40; i++) begin
      @(posedge i_clk);
      if (o_holdover === h && (h || o_active_ref === x)) break;
    end
    chk({13'h0, o_holdover, h ? 2'h0 : o_active_ref},
      {13'h0, h, h ? 2'h0 : x});
  endtask : wait_ref
  task automatic clk_seen(input logic e);
    logic s;
    s = 1'b0;
    repeat (3) @(posedge i_clk);
    repeat (40) begin
      @(posedge i_clk);
      s = s | (|o_clk_out) | (|o_frame_pulse);
    end
    chk({15'h0, s}, {15'h0, e});
  endtask : clk_seen

  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      test_done();
    end
  end

  initial begin
    i_rst_n = 1'b0;
    i_ce = 1'b1;
    i_slave_mode = 1'b0;
    slow = 1'b0;
    req = '0;
    want_valid = 4'h0;
    void'($urandom(32'h5dba));
    repeat (20) @(posedge i_clk);
    i_rst_n <= 1'b1;
    for (int a = 0; a < 6; a++) begin
      rdchk(a[2:0], rst_tab[a]);
    end
    for (int i = 0; i < 6; i++) begin
      r = 2'($urandom_range(3));
      slow <= 1'($urandom_range(1));
      want_valid <= 4'h1 << r;
      wait_ref(r, 1'b0);
      want_valid <= ~(4'h1 << r);
      wait_ref(nxt(r), 1'b0);
    end
    want_valid <= 4'h0;
    wait_ref(2'h0, 1'b1);
    for (int p = 0; p < 4; p++) begin
      r = p[1:0];
      wr(`DMR_OFS_REF_CHG, rcc(r, `DMR_PMS_PREF, DMR_OPM_AUTO));
      want_valid <= 4'h1 << nxt(r);
      wait_ref(nxt(r), 1'b0);
      want_valid <= 4'hF;
      wait_ref(r, 1'b0);
      want_valid <= 4'h1 << nxt(nxt(r));
      wait_ref(2'h0, 1'b1);
      // host moves the preference to the one surviving reference
      wr(`DMR_OFS_REF_CHG, rcc(nxt(nxt(r)), `DMR_PMS_PREF, DMR_OPM_AUTO));
      wait_ref(nxt(nxt(r)), 1'b0);
    end
    r = 2'($urandom_range(3));
    want_valid <= 4'hF;
    wr(`DMR_OFS_REF_CHG, rcc(r, `DMR_PMS_NONE, DMR_OPM_NORMAL));
    wait_ref(r, 1'b0);
    wr(`DMR_OFS_REF_CHG, rcc(r, `DMR_PMS_NONE, DMR_OPM_HOLD));
    wait_ref(2'h0, 1'b1);
    wr(`DMR_OFS_BW_CTRL, `DMR_RST_BW_CTRL);
    wr(`DMR_OFS_REF_CHG, rcc(2'h0, `DMR_PMS_NONE, DMR_OPM_FREE));
    rd(`DMR_OFS_STATUS, v);
    chk(v & 16'h007C, 16'h0060);
    wr(`DMR_OFS_FREQ, 16'($urandom));
    wr(`DMR_OFS_SOFT_DF, 16'($urandom_range(16'h0fff)) + 16'h0010);
    repeat (4) @(posedge i_clk);
    rdchk(`DMR_OFS_FREQ, 16'h0000);
    wr(`DMR_OFS_LOOP_CTRL, 16'h0018);
    v = 16'($urandom_range(16'h0fff));
    wr(`DMR_OFS_SOFT_DF, v);
    repeat (2) @(posedge i_clk);
    rdchk(`DMR_OFS_FREQ, v);
    wr(`DMR_OFS_LOOP_CTRL, 16'h0008);
    tgt = v + 16'h0040;
    wr(`DMR_OFS_SOFT_DF, tgt);
    rd(`DMR_OFS_FREQ, v);
    chk({15'h0, v !== tgt}, 16'h0001);
    repeat (100) @(posedge i_clk);
    rdchk(`DMR_OFS_FREQ, tgt);
    wr(`DMR_OFS_LOOP_CTRL, 16'h0001);
    clk_seen(1'b0);
    for (int i = 2; i < 6; i++) begin
      v = 16'($urandom) & 16'hDFFF;
      wr(i[2:0], v);
      rdchk(i[2:0], v & (i == 4 ? 16'h3FFF : 16'hFFFF));
    end
    v = rcc(2'h0, `DMR_PMS_NONE, DMR_OPM_FREE);
    rdchk(`DMR_OFS_REF_CHG, v);
    wr(`DMR_OFS_CENTRE, `DMR_RST_CENTRE);
    wr(`DMR_OFS_BW_CTRL, `DMR_RST_BW_CTRL);
    wr(`DMR_OFS_LOOP_CTRL, 16'h0000);
    clk_seen(1'b1);
    rd(`DMR_OFS_STATUS, v);
    chk(v & 16'h007C, 16'h0060);
    i_slave_mode <= 1'b1;
    clk_seen(1'b0);
    wr(`DMR_OFS_LOOP_CTRL, 16'h0020);
    clk_seen(1'b1);
    // clock enable low: clocks frozen, a write is not taken
    i_ce <= 1'b0;
    wr(`DMR_OFS_CENTRE, 16'h0000);
    repeat (2) @(posedge i_clk);
    v = {10'h000, o_clk_out};
    repeat (10) @(posedge i_clk);
    chk({10'h000, o_clk_out}, v);
    i_ce <= 1'b1;
    rdchk(`DMR_OFS_CENTRE, `DMR_RST_CENTRE);
    test_done();
  end
endmodule : dpll_mode_reference_control_test
